// [logic/battery_charge_sequencer.sv]
// charge-control sequencer of a switch-mode lithium charger
// assumes comparator flags and pins are asynchronous levels
//
// Summary of operation
// RL1 - switch synchronously only while low-side current exceeds 100mA
// RL2 - end high-side conduction in a cycle once peak 3.6A limit flags
// RL3 - start a cycle only with temperature in low-to-high window
// RL4 - while charging keep temperature in low-to-cutoff window, else suspend; here only precharge and fast charge suspend, CV ignores it
// RL5 - suspend stops switching and freezes, not resets, the safety timer
// RL6 - below precharge-exit threshold apply precharge current, run its timer
// RL7 - precharge timeout stops charge, reports fault, applies detect current; here detect current only while below the recharge threshold
// RL8 - precharge fault held until reset or battery replacement; here a timer control rise or software restart also exits the fault
// RL9 - in constant voltage end charge at termination current
// RL10 - cell select low gives 4.2 V target, high gives 8.4 V
// RL11 - restart on recharge threshold, reset, enable toggle or timer enable
// RL12 - timer control low disables termination and safety timer
// RL13 - timer control rising re-enables both and clears timer count
// RL14 - timer control tied high disables only the safety timer
// RL15 - supply absent puts the sequencer into low-power sleep
// RL16 - status: charging a on b off, done a off b on, else both off
// RL17 - charge enable low allows charging; falling edge clears timers, faults
// RL18 - power good on above sleep exit, off in sleep
// RL19 - overvoltage stops switching, both status off, clears at recharge
// RL20 - every flag and pin passes a two-stage synchroniser
// RL21 - timeouts count prescaled ticks with configurable terminal counts
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "charge_seq_regs.svh"
module battery_charge_sequencer
  import charge_seq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        supply_ok,
  input  wire logic        bat_below_lowv,
  input  wire logic        bat_below_rech,
  input  wire logic        bat_at_reg,
  input  wire logic        bat_overvolt,
  input  wire logic        temp_in_start,
  input  wire logic        temp_in_run,
  input  wire logic        term_current,
  input  wire logic        peak_limit,
  input  wire logic        lowside_above_min,
  input  wire logic        pwm_on,
  input  wire logic        bat_replaced,
  input  wire logic        charge_en_n,
  input  wire logic        cell_select,
  input  wire logic        timer_term_ctrl,
  input  wire logic        timer_term_ctrl_high,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             high_side_on,
  output logic             low_side_on,
  output logic             precharge_sel,
  output logic             fast_sel,
  output logic             detect_current,
  output logic             two_cell_target,
  output logic             status_out_a_o,
  output logic             status_out_a_oe,
  output logic             status_out_b_o,
  output logic             status_out_b_oe,
  output logic             power_good_n_o,
  output logic             power_good_n_oe
);
  localparam int NFLAG = 16;

  logic [NFLAG-1:0] raw_flags;
  logic [NFLAG-1:0] sf;
  logic s_supply, s_lowv, s_rech, s_at_reg, s_ov, s_t_start, s_t_run;
  logic s_term, s_peak, s_ls_ok, s_pwm, s_repl, s_ce_n, s_cells, s_ttc;
  logic s_ttc_high;

  logic [31:0] ctrl_q, pre_lim_q, fast_lim_q, tick_q;
  logic [31:0] status_word, timer_word;

  charge_state_t state_q;
  charge_state_t state_d;
  charge_state_t resume_q;
  logic [31:0]   presc_q;
  logic [31:0]   timer_q;
  logic          tick, ce_n_q, ttc_q, ce_fall, ttc_rise, restart;
  logic          fault_q, ov_q, timer_en, term_en, charging, timer_clr;
  logic          timed_out, inhibit, first_q, cycle_cut_q;

  // ============================================================
  // input synchronisers
  assign raw_flags = {timer_term_ctrl_high, timer_term_ctrl, cell_select,
                      charge_en_n, bat_replaced, pwm_on, lowside_above_min,
                      peak_limit, term_current, temp_in_run, temp_in_start,
                      bat_overvolt, bat_at_reg, bat_below_rech,
                      bat_below_lowv, supply_ok};

  flag_sync #(.WIDTH(NFLAG)) u_sync ( // [RL20]
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (raw_flags),
    .sync_out (sf)
  );

  assign {s_ttc_high, s_ttc, s_cells, s_ce_n, s_repl, s_pwm, s_ls_ok,
          s_peak, s_term, s_t_run, s_t_start, s_ov, s_at_reg, s_rech,
          s_lowv, s_supply} = sf;

  // ============================================================
  // register slave
  axil_regs u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status_word   (status_word),
    .timer_word    (timer_word),
    .ctrl_q        (ctrl_q),
    .pre_lim_q     (pre_lim_q),
    .fast_lim_q    (fast_lim_q),
    .tick_q        (tick_q)
  );

  // ============================================================
  // edge detection on synchronised pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ce_n_q  <= 1'b0;
      ttc_q   <= 1'b0;
      first_q <= 1'b1;
    end else begin
      ce_n_q  <= s_ce_n;
      ttc_q   <= s_ttc;
      first_q <= 1'b0;
    end
  end

  assign ce_fall  = ce_n_q && !s_ce_n; // [RL17]
  assign ttc_rise = !ttc_q && s_ttc;   // [RL13]
  // software restart counts as a timer control rising edge
  assign restart  = ce_fall || ttc_rise || ctrl_q[`CTRL_FORCE_RESTART];
  assign inhibit  = s_ce_n || ctrl_q[`CTRL_SW_INHIBIT]; // [RL17]

  // tied-high timer control keeps termination; low disables both
  assign term_en  = s_ttc;                  // [RL12] [RL14]
  assign timer_en = s_ttc && !s_ttc_high;   // [RL12] [RL14]

  // ============================================================
  // safety timer, counted in prescaled ticks
  assign tick = (presc_q >= tick_q - 32'd1); // [RL21]
  assign charging = (state_q == ST_PRECHG) || (state_q == ST_FASTCHG) ||
                    (state_q == ST_CVCHG);
  assign timer_clr = restart || (state_q == ST_QUALIFY) || !s_supply;
  assign timed_out = timer_en &&
    (((state_q == ST_PRECHG) && (timer_q >= pre_lim_q)) ||
     ((state_q != ST_PRECHG) && (timer_q >= fast_lim_q))); // [RL21]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 32'h0000_0000;
    end else if (tick || !charging) begin
      presc_q <= 32'h0000_0000;
    end else begin
      presc_q <= presc_q + 32'd1;
    end
  end

  // suspend leaves the count untouched so it resumes where it stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_q <= 32'h0000_0000;
    end else if (timer_clr) begin
      timer_q <= 32'h0000_0000; // [RL13] [RL17]
    end else if (charging && timer_en && tick) begin
      timer_q <= timer_q + 32'd1; // [RL5]
    end
  end

  // ============================================================
  // fault latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
    end else if (charging && timed_out) begin
      fault_q <= 1'b1; // [RL7]
    end else if (ce_fall || s_repl) begin
      fault_q <= 1'b0; // [RL8] [RL17]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_q <= 1'b0;
    end else if (s_ov) begin
      ov_q <= 1'b1; // [RL19]
    end else if (s_rech || ce_fall) begin
      ov_q <= 1'b0; // [RL19]
    end
  end

  // ============================================================
  // charge state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP: begin
        if (s_supply) state_d = ST_QUALIFY;
      end
      ST_QUALIFY: begin
        if (inhibit) state_d = ST_INHIBIT;
        else if (!s_t_start) state_d = ST_QUALIFY; // [RL3]
        else if (s_lowv) state_d = ST_PRECHG; // [RL6]
        else state_d = ST_FASTCHG;
      end
      ST_PRECHG: begin
        if (timed_out) state_d = ST_FAULT; // [RL7]
        else if (!s_t_run) state_d = ST_SUSPEND; // [RL4]
        else if (!s_lowv) state_d = ST_FASTCHG;
      end
      ST_FASTCHG: begin
        if (timed_out) state_d = ST_FAULT;
        else if (!s_t_run) state_d = ST_SUSPEND; // [RL4]
        else if (s_at_reg) state_d = ST_CVCHG;
      end
      ST_CVCHG: begin
        if (timed_out) state_d = ST_FAULT;
        else if (term_en && s_term) state_d = ST_DONE; // [RL9]
      end
      ST_SUSPEND: begin
        if (s_t_run) state_d = resume_q; // [RL5]
      end
      ST_DONE: begin
        if (s_rech) state_d = ST_QUALIFY; // [RL11]
      end
      ST_FAULT: begin
        if (!fault_q) state_d = ST_QUALIFY; // [RL8]
      end
      ST_OVERVOLT: begin
        if (!ov_q) state_d = ST_QUALIFY; // [RL19]
      end
      ST_INHIBIT: begin
        if (!inhibit) state_d = ST_QUALIFY; // [RL17]
      end
      default: state_d = ST_SLEEP;
    endcase
    // overriding conditions, the last assignment wins, so most severe last
    if (restart && state_q != ST_SLEEP && !ov_q) state_d = ST_QUALIFY;
    if (first_q && s_rech) state_d = ST_QUALIFY; // [RL11]
    if (inhibit && charging) state_d = ST_INHIBIT; // [RL17]
    if (ov_q || s_ov) state_d = ST_OVERVOLT; // [RL19]
    if (!s_supply) state_d = ST_SLEEP; // [RL15]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= ST_SLEEP;
      resume_q <= ST_PRECHG;
    end else begin
      state_q <= state_d;
      if (state_d == ST_SUSPEND && state_q != ST_SUSPEND) begin
        resume_q <= state_q;
      end
    end
  end

  // ============================================================
  // switching stage gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_cut_q <= 1'b0;
    end else if (!s_pwm) begin
      cycle_cut_q <= 1'b0;
    end else if (s_peak) begin
      cycle_cut_q <= 1'b1; // [RL2]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_side_on    <= 1'b0;
      low_side_on     <= 1'b0;
      precharge_sel   <= 1'b0;
      fast_sel        <= 1'b0;
      detect_current  <= 1'b0;
      two_cell_target <= 1'b0;
    end else begin
      high_side_on   <= charging && s_pwm && !s_peak &&
                        !cycle_cut_q; // [RL2] [RL5]
      low_side_on    <= charging && !s_pwm && s_ls_ok; // [RL1]
      precharge_sel  <= (state_q == ST_PRECHG); // [RL6]
      fast_sel       <= (state_q == ST_FASTCHG) ||
                        (state_q == ST_CVCHG);
      detect_current <= (state_q == ST_FAULT) && s_rech; // [RL7]
      two_cell_target <= s_cells; // [RL10]
    end
  end

  // ============================================================
  // open-drain status pins, enable high means pin pulled low (on)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_out_a_oe <= 1'b0;
      status_out_b_oe <= 1'b0;
      power_good_n_oe <= 1'b0;
    end else begin
      status_out_a_oe <= charging; // [RL16]
      status_out_b_oe <= (state_q == ST_DONE); // [RL16]
      power_good_n_oe <= s_supply && (state_q != ST_SLEEP); // [RL18]
    end
  end

  assign status_out_a_o = 1'b0;
  assign status_out_b_o = 1'b0;
  assign power_good_n_o = 1'b0;

  assign status_word = {22'h000000, term_en, timer_en, low_side_on,
                        two_cell_target, ov_q, fault_q, state_q};
  assign timer_word  = timer_q;
endmodule // battery_charge_sequencer
`default_nettype wire

// [logic/charge_seq_regs.svh]
// register offsets, fields, reset values and timing counts
// assumes inclusion by bare name from the design files
`ifndef CHARGE_SEQ_REGS_SVH
`define CHARGE_SEQ_REGS_SVH
// ============================================================
// register byte offsets
`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_TIMER_OFS     8'h08
`define REG_PRE_LIM_OFS   8'h0C
`define REG_FAST_LIM_OFS  8'h10
`define REG_TICK_OFS      8'h14
// ============================================================
// control fields
`define CTRL_SW_INHIBIT   0
`define CTRL_FORCE_RESTART 1
// ============================================================
// reset values (timeouts in ticks, tick prescale in clocks)
`define PRE_LIM_RESET     32'h0000_0100
`define FAST_LIM_RESET    32'h0000_1000
`define TICK_RESET        32'h0000_C350
`define CTRL_RESET        32'h0000_0000
// ============================================================
// bus response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// [logic/charge_seq_pkg.sv]
// types shared by the charge sequencer files
// assumes nothing of its surroundings
package charge_seq_pkg;
  typedef enum logic [3:0] {
    ST_SLEEP    = 4'b0000,
    ST_QUALIFY  = 4'b0001,
    ST_PRECHG   = 4'b0010,
    ST_FASTCHG  = 4'b0011,
    ST_CVCHG    = 4'b0100,
    ST_DONE     = 4'b0101,
    ST_SUSPEND  = 4'b0110,
    ST_FAULT    = 4'b0111,
    ST_OVERVOLT = 4'b1000,
    ST_INHIBIT  = 4'b1001
  } charge_state_t;
endpackage

// [logic/flag_sync.sv]
// two-stage synchroniser for a bundle of asynchronous flags
// assumes flags are static levels relative to the clock
`timescale 1ns/1ps
`default_nettype none
module flag_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // flag_sync
`default_nettype wire

// [logic/axil_regs.sv]
// axi4-lite slave holding the sequencer control and status words
// assumes one outstanding write and one outstanding read from the master
`timescale 1ns/1ps
`default_nettype none
`include "charge_seq_regs.svh"
module axil_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] status_word,
  input  wire logic [31:0] timer_word,
  output logic [31:0]      ctrl_q,
  output logic [31:0]      pre_lim_q,
  output logic [31:0]      fast_lim_q,
  output logic [31:0]      tick_q
);
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // ============================================================
  // write path: address and data may arrive in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q       <= `CTRL_RESET;
      pre_lim_q    <= `PRE_LIM_RESET;
      fast_lim_q   <= `FAST_LIM_RESET;
      tick_q       <= `TICK_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (awaddr_q[7:2] == `REG_CTRL_OFS >> 2) begin
          ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        end else if (awaddr_q[7:2] == `REG_PRE_LIM_OFS >> 2) begin
          pre_lim_q <= merge(pre_lim_q, wdata_q, wstrb_q);
        end else if (awaddr_q[7:2] == `REG_FAST_LIM_OFS >> 2) begin
          fast_lim_q <= merge(fast_lim_q, wdata_q, wstrb_q);
        end else if (awaddr_q[7:2] == `REG_TICK_OFS >> 2) begin
          tick_q <= merge(tick_q, wdata_q, wstrb_q);
        end else if (awaddr_q[7:2] != `REG_STATUS_OFS >> 2 &&
                     awaddr_q[7:2] != `REG_TIMER_OFS >> 2) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // read path: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      if (s_axi_araddr[7:2] == `REG_CTRL_OFS >> 2) begin
        s_axi_rdata <= ctrl_q;
      end else if (s_axi_araddr[7:2] == `REG_STATUS_OFS >> 2) begin
        s_axi_rdata <= status_word;
      end else if (s_axi_araddr[7:2] == `REG_TIMER_OFS >> 2) begin
        s_axi_rdata <= timer_word;
      end else if (s_axi_araddr[7:2] == `REG_PRE_LIM_OFS >> 2) begin
        s_axi_rdata <= pre_lim_q;
      end else if (s_axi_araddr[7:2] == `REG_FAST_LIM_OFS >> 2) begin
        s_axi_rdata <= fast_lim_q;
      end else if (s_axi_araddr[7:2] == `REG_TICK_OFS >> 2) begin
        s_axi_rdata <= tick_q;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // axil_regs
`default_nettype wire

// [tb/charge_seq_checker.sv]
// assertions on the charge sequencer pins
// assumes a bind onto battery_charge_sequencer
`timescale 1ns/1ps
`default_nettype none
module charge_seq_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supply_ok,
  input wire logic bat_overvolt,
  input wire logic peak_limit,
  input wire logic lowside_above_min,
  input wire logic cell_select,
  input wire logic charge_en_n,
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic detect_current,
  input wire logic two_cell_target,
  input wire logic status_out_a_oe,
  input wire logic status_out_b_oe,
  input wire logic power_good_n_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ============================================================
  // held inputs, long enough to cover synchroniser latency
  sequence s_ov_held;
    bat_overvolt [*7];
  endsequence
  sequence s_no_supply;
    !supply_ok [*7];
  endsequence
  chk_status_excl:
    assert property (!(status_out_a_oe && status_out_b_oe))
    else $error("both status pins on");
  chk_ov_quiet:
    assert property (s_ov_held |-> !high_side_on && !status_out_a_oe
      && !status_out_b_oe) else $error("overvoltage not quiet");
  chk_sleep_quiet:
    assert property (s_no_supply |-> !power_good_n_oe && !high_side_on
      && !status_out_a_oe) else $error("sleep not quiet");
  chk_peak_cut:
    assert property (peak_limit [*4] |-> !high_side_on)
    else $error("peak limit");
  chk_no_reverse:
    assert property (!lowside_above_min [*4] |-> !low_side_on)
    else $error("reverse current");
  chk_cell_target:
    assert property ((supply_ok && $stable(cell_select)) [*6]
      |-> two_cell_target == cell_select) else $error("cell target");
  chk_detect_quiet:
    assert property (detect_current |-> !high_side_on
      && !status_out_a_oe && !status_out_b_oe) else $error("detect");
  chk_inhibit_stop:
    assert property (charge_en_n [*6] |-> !high_side_on && !status_out_a_oe)
    else $error("inhibit");
endmodule // charge_seq_checker
`default_nettype wire

// [tb/status_led_model.sv]
// leds on the open-drain status and power-good pins
// assumes pull-ups, so a released pin reads high
`timescale 1ns/1ps
`default_nettype none
module status_led_model (
  input  wire logic a_o,
  input  wire logic a_oe,
  input  wire logic b_o,
  input  wire logic b_oe,
  input  wire logic pg_o,
  input  wire logic pg_oe,
  output logic      a_lit,
  output logic      b_lit,
  output logic      pg_lit
);
  // ============================================================
  // a led lights only while its pin is pulled low
  assign a_lit = a_oe && !a_o;
  assign b_lit = b_oe && !b_o;
  assign pg_lit = pg_oe && !pg_o;
endmodule // status_led_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the charge sequencer
// assumes the design files compile first
`timescale 1ns/1ps
`default_nettype none
`include "charge_seq_regs.svh"
module tb_top;
  logic aclk = 0, aresetn = 0, supply_ok = 0, bat_below_lowv = 1;
  logic bat_below_rech = 1, bat_at_reg = 0, bat_overvolt = 0;
  logic temp_in_start = 1, temp_in_run = 1, term_current = 0;
  logic peak_limit = 0, lowside_above_min = 1, pwm_on = 0;
  logic bat_replaced = 0, charge_en_n = 0, cell_select = 0;
  logic timer_term_ctrl = 1, timer_term_ctrl_high = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic high_side_on, low_side_on, precharge_sel, fast_sel;
  logic detect_current, two_cell_target, a_lit, b_lit, pg_lit;
  logic status_out_a_o, status_out_a_oe, status_out_b_o;
  logic status_out_b_oe, power_good_n_o, power_good_n_oe;
  int bad_count = 0, checked = 0;
  battery_charge_sequencer u_dut (.*);
  status_led_model u_leds (.a_o(status_out_a_o), .a_oe(status_out_a_oe),
    .b_o(status_out_b_o), .b_oe(status_out_b_oe), .pg_o(power_good_n_o),
    .pg_oe(power_good_n_oe), .a_lit(a_lit), .b_lit(b_lit), .pg_lit(pg_lit));
  initial forever #10 aclk = ~aclk;
  // ============================================================
  // checks and bus access
  task automatic results();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic aw, w, b;
    b = 0;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    chk("write_done", 1, b);
    if (!b) results();
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e, string n,
                       logic [1:0] r = `RESP_OKAY);
    logic ar, v;
    v = 0;
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    for (int i = 0; i < 50 && !v; i++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    if (n != "skip") chk(n, e, rdat);
    chk("rresp", r, rsp);
    if (!v) results();
  endtask
  function automatic logic pick(int k);
    case (k)
      0: return a_lit;
      1: return b_lit;
      2: return pg_lit;
      3: return detect_current;
      default: return precharge_sel;
    endcase
  endfunction
  task automatic wait_for(int k, logic v, string n);
    for (int i = 0; i < 3000 && pick(k) !== v; i++) @(negedge aclk);
    chk(n, v, pick(k));
    if (pick(k) !== v) results();
    @(posedge aclk);
  endtask
  task automatic hold(int k, logic v, string n, int c);
    repeat (c) begin
      @(negedge aclk);
      chk(n, v, pick(k));
    end
    @(posedge aclk);
  endtask
  // ============================================================
  // scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(`REG_PRE_LIM_OFS, `PRE_LIM_RESET, "pre_lim");
    rdchk(`REG_FAST_LIM_OFS, `FAST_LIM_RESET, "fast_lim");
    rdchk(`REG_TICK_OFS, `TICK_RESET, "tick");
    rdchk(8'h40, 32'h0, "unmapped", `RESP_SLVERR);
    wr(`REG_TICK_OFS, 32'h2);
    rdchk(`REG_TICK_OFS, 32'h2, "tick_wr");
    hold(2, 1'b0, "pg_asleep", 8);
    $display("test registers done");
    {supply_ok, pwm_on} <= 2'h3;
    wait_for(2, 1'b1, "pg_on");
    wait_for(4, 1'b1, "precharge");
    wait_for(0, 1'b1, "charging_a");
    {peak_limit, lowside_above_min, temp_in_run} <= 3'h4;
    wait_for(0, 1'b0, "suspend_a");
    {peak_limit, lowside_above_min} <= 2'h1;
    rdchk(`REG_TIMER_OFS, rdat, "skip");
    rdchk(`REG_TIMER_OFS, rdat, "timer_frozen");
    temp_in_run <= 1'b1;
    wait_for(0, 1'b1, "resume_a");
    wr(`REG_PRE_LIM_OFS, 32'h4);
    wait_for(3, 1'b1, "detect");
    hold(0, 1'b0, "fault_held", 40);
    wr(`REG_PRE_LIM_OFS, `PRE_LIM_RESET);
    bat_replaced <= 1'b1;
    repeat (6) @(posedge aclk);
    bat_replaced <= 1'b0;
    wait_for(3, 1'b0, "fault_clear");
    $display("test precharge done");
    timer_term_ctrl <= 1'b0;
    wr(`REG_PRE_LIM_OFS, 32'h4);
    hold(3, 1'b0, "no_timeout", 100);
    wr(`REG_PRE_LIM_OFS, `PRE_LIM_RESET);
    timer_term_ctrl <= 1'b1;
    hold(3, 1'b0, "timer_reset", 40);
    $display("test timer_ctrl done");
    {bat_below_lowv, bat_below_rech, bat_at_reg} <= 3'b001;
    term_current <= 1'b1;
    wait_for(1, 1'b1, "done_b");
    {term_current, bat_overvolt} <= 2'h1;
    wait_for(1, 1'b0, "ov_off");
    {bat_overvolt, bat_below_rech} <= 2'h1;
    wait_for(0, 1'b1, "recharge");
    $display("test done_ov done");
    charge_en_n <= 1'b1;
    wait_for(0, 1'b0, "inhibit");
    {charge_en_n, cell_select} <= 2'h1;
    wait_for(0, 1'b1, "ce_restart");
    chk("two_cell", 1, two_cell_target);
    supply_ok <= 1'b0;
    wait_for(2, 1'b0, "sleep_pg");
    wait_for(0, 1'b0, "sleep_a");
    $display("test enable_sleep done");
    results();
  end
endmodule // tb_top
bind battery_charge_sequencer charge_seq_checker u_chk (.*);
`default_nettype wire
